/* pkg/acf_pkg.sv */
// Constants, register map and carrier types of the calibration controller
package acf_pkg;

    localparam int ACF_CNT_W = 24;

    // Clock period and timing figures
    localparam int ACF_CLK_NS       = 40;
    localparam int ACF_DLY_SHORT_NS = 100_000;
    localparam int ACF_DLY_LONG_NS  = 10_000_000;
    localparam int ACF_CAL_RUN_NS   = 56_000;
    localparam logic [ACF_CNT_W-1:0] ACF_DLY_SHORT_CYC =
        ACF_CNT_W'((ACF_DLY_SHORT_NS + ACF_CLK_NS - 1) / ACF_CLK_NS);
    localparam logic [ACF_CNT_W-1:0] ACF_DLY_LONG_CYC =
        ACF_CNT_W'((ACF_DLY_LONG_NS + ACF_CLK_NS - 1) / ACF_CLK_NS);
    localparam logic [ACF_CNT_W-1:0] ACF_CAL_RUN_CYC =
        ACF_CNT_W'((ACF_CAL_RUN_NS + ACF_CLK_NS - 1) / ACF_CLK_NS);

    // Request pin qualification counts, in clock cycles
    localparam logic [7:0] ACF_T_CAL_L_CYC = 8'h50;
    localparam logic [7:0] ACF_T_CAL_H_CYC = 8'h50;

    // Register byte offsets
    localparam logic [7:0] ACF_OFS_CTRL   = 8'h00;
    localparam logic [7:0] ACF_OFS_STATUS = 8'h04;
    localparam logic [7:0] ACF_OFS_RESULT = 8'h08;

    // Control register fields and reset values
    localparam int         ACF_CTRL_DIV_BIT  = 0;
    localparam int         ACF_CTRL_CAL_BIT  = 1;
    localparam logic       ACF_CTRL_DIV_RST  = 1'b0;

    // Status register fields
    localparam int ACF_STAT_ACTIVE_BIT = 0;
    localparam int ACF_STAT_OOR_BIT    = 1;
    localparam int ACF_STAT_DONE_BIT   = 2;
    localparam int ACF_STAT_SKIP_BIT   = 3;
    localparam int ACF_STAT_FSR_BIT    = 4;

    // Result register fields
    localparam int ACF_RES_I_LSB = 0;
    localparam int ACF_RES_Q_LSB = 8;

    // Output data clock divider counts, minus one
    localparam logic [1:0] ACF_DIV_FAST = 2'h0;
    localparam logic [1:0] ACF_DIV_SLOW = 2'h3;

    localparam logic [7:0] ACF_CODE_MAX = 8'hFF;
    localparam logic [7:0] ACF_CODE_MIN = 8'h00;

    typedef struct packed {
        logic signed [9:0] i_val;
        logic signed [9:0] q_val;
    } acf_raw_t;

    typedef struct packed {
        logic [7:0] i_code;
        logic [7:0] q_code;
    } acf_sample_t;

    typedef enum logic [1:0] {
        ACF_ST_STRAP,
        ACF_ST_DELAY,
        ACF_ST_CAL,
        ACF_ST_IDLE
    } acf_state_t;

endpackage : acf_pkg

/* hdl/acf_ahb_slave.sv */
// AHB-Lite slave front end for the calibration controller registers
module acf_ahb_slave
    import acf_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [31:0] ctrl_word,
    input  wire logic [31:0] status_word,
    input  wire logic [31:0] result_word,
    output logic             ctrl_wr,
    output logic      [31:0] ctrl_wdata
);

    logic        wr_pend_q;
    logic [7:0]  wr_ofs_q;
    logic [31:0] hrdata_q;
    logic        take;
    logic [31:0] rd_mux;

    // Accept only address phases with a transfer (NONSEQ or SEQ)
    assign take      = hsel && htrans[1] && hready;
    assign rd_mux    = (haddr[7:0] == ACF_OFS_CTRL)   ? ctrl_word   :
                       (haddr[7:0] == ACF_OFS_STATUS) ? status_word :
                       (haddr[7:0] == ACF_OFS_RESULT) ? result_word :
                       32'h0000_0000;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = hrdata_q;
    assign ctrl_wr    = wr_pend_q && (wr_ofs_q == ACF_OFS_CTRL);
    assign ctrl_wdata = hwdata;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_ofs_q  <= 8'h00;
            hrdata_q  <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_q <= take && hwrite;
            if (take)
            begin
                wr_ofs_q <= haddr[7:0];
            end
            if (take && !hwrite)
            begin
                hrdata_q <= (haddr[31:8] == 24'h00_0000) ? rd_mux
                                                         : 32'h0000_0000;
            end
        end
    end

endmodule : acf_ahb_slave

/* hdl/acf_ctrl.sv */
// Calibration sequencer, range flag and output clock gating of the converter
module acf_ctrl
    import acf_pkg::*;
#(
    parameter logic [ACF_CNT_W-1:0] DLY_LONG_CYC = ACF_DLY_LONG_CYC
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        calibration_request,
    input  wire logic        calibration_delay_select,
    input  wire logic        power_down_input,
    input  wire logic        full_scale_select,
    input  wire logic        output_clock_reset,
    input  wire acf_raw_t    raw_result,
    output acf_sample_t      sample_out,
    output logic             out_of_range_pos,
    output logic             out_of_range_neg,
    output logic             calibration_active,
    output logic             full_scale_normal,
    output logic             output_data_clock
);

    function automatic logic [7:0] clip_code(input logic signed [9:0] v);
        if (v > $signed({2'b00, ACF_CODE_MAX}))
            clip_code = ACF_CODE_MAX;
        else if (v < $signed({2'b00, ACF_CODE_MIN}))
            clip_code = ACF_CODE_MIN;
        else
            clip_code = v[7:0];
    endfunction : clip_code

    function automatic logic outside(input logic signed [9:0] v);
        outside = (v > $signed({2'b00, ACF_CODE_MAX})) ||
                  (v < $signed({2'b00, ACF_CODE_MIN}));
    endfunction : outside

    acf_state_t             state_q;
    acf_state_t             state_d;
    logic [ACF_CNT_W-1:0]   cnt_q;
    logic [ACF_CNT_W-1:0]   cnt_d;
    logic [7:0]             low_cnt_q;
    logic [7:0]             high_cnt_q;
    logic                   armed_q;
    logic                   skipped_q;
    logic                   done_q;
    logic                   cal_active_q;
    logic                   div_sel_q;
    logic                   soft_cal_q;
    logic [1:0]             div_cnt_q;
    logic                   oclk_q;
    logic                   or_pos_q;
    logic                   or_neg_q;
    logic                   fsr_q;
    acf_sample_t            sample_q;

    logic                   ctrl_wr;
    logic [31:0]            ctrl_wdata;
    logic [31:0]            ctrl_word;
    logic [31:0]            status_word;
    logic [31:0]            result_word;
    logic [ACF_CNT_W-1:0]   dly_target;
    logic                   dly_done;
    logic                   cal_done;
    logic                   pin_trigger;
    logic                   start_cal;
    logic                   clip_now;
    logic [1:0]             div_top;
    logic                   div_tick;

    acf_ahb_slave u_bus (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .hsel        (hsel),
        .haddr       (haddr),
        .htrans      (htrans),
        .hwrite      (hwrite),
        .hsize       (hsize),
        .hwdata      (hwdata),
        .hready      (hready),
        .hrdata      (hrdata),
        .hreadyout   (hreadyout),
        .hresp       (hresp),
        .ctrl_word   (ctrl_word),
        .status_word (status_word),
        .result_word (result_word),
        .ctrl_wr     (ctrl_wr),
        .ctrl_wdata  (ctrl_wdata)
    );

    assign ctrl_word   = {31'h0000_0000, div_sel_q};
    assign status_word = {27'h000_0000, fsr_q, skipped_q, done_q,
                          or_pos_q, cal_active_q};
    assign result_word = {16'h0000, sample_q.q_code, sample_q.i_code};

    // Delay length picked by the select input
    assign dly_target = calibration_delay_select ? DLY_LONG_CYC
                                                 : ACF_DLY_SHORT_CYC;
    assign dly_done   = (cnt_q == dly_target - 24'h00_0001);
    assign cal_done   = (cnt_q == ACF_CAL_RUN_CYC - 24'h00_0001);
    // Pin held low long enough, then high long enough
    assign pin_trigger = armed_q && calibration_request &&
                         (high_cnt_q == ACF_T_CAL_H_CYC - 8'h01);
    assign start_cal   = (state_q == ACF_ST_IDLE) &&
                         (pin_trigger || soft_cal_q);

    // Next state; the sequence counts clock edges only
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            ACF_ST_STRAP:
            begin
                cnt_d   = '0;
                state_d = calibration_request ? ACF_ST_IDLE
                                              : ACF_ST_DELAY;
            end
            ACF_ST_DELAY:
            begin
                if (!power_down_input)
                begin
                    cnt_d = cnt_q + 24'h00_0001;
                    if (dly_done)
                    begin
                        cnt_d   = '0;
                        state_d = ACF_ST_CAL;
                    end
                end
            end
            ACF_ST_CAL:
            begin
                cnt_d = cnt_q + 24'h00_0001;
                if (cal_done)
                begin
                    cnt_d   = '0;
                    state_d = ACF_ST_IDLE;
                end
            end
            ACF_ST_IDLE:
            begin
                cnt_d = '0;
                if (start_cal)
                begin
                    state_d = ACF_ST_CAL;
                end
            end
            default:
            begin
                cnt_d   = '0;
                state_d = ACF_ST_STRAP;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q      <= ACF_ST_STRAP;
            cnt_q        <= '0;
            cal_active_q <= 1'b0;
            skipped_q    <= 1'b0;
            done_q       <= 1'b0;
        end
        else
        begin
            state_q      <= state_d;
            cnt_q        <= cnt_d;
            cal_active_q <= (state_d == ACF_ST_CAL);
            if (state_q == ACF_ST_STRAP && calibration_request)
                skipped_q <= 1'b1;
            if (state_q == ACF_ST_CAL && cal_done)
                done_q <= 1'b1;
        end
    end

    // Request pin qualification in idle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            low_cnt_q  <= 8'h00;
            high_cnt_q <= 8'h00;
            armed_q    <= 1'b0;
        end
        else if (state_q != ACF_ST_IDLE || start_cal)
        begin
            low_cnt_q  <= 8'h00;
            high_cnt_q <= 8'h00;
            armed_q    <= 1'b0;
        end
        else if (!calibration_request)
        begin
            high_cnt_q <= 8'h00;
            if (low_cnt_q == ACF_T_CAL_L_CYC - 8'h01)
                armed_q <= 1'b1;
            else
                low_cnt_q <= low_cnt_q + 8'h01;
        end
        else if (armed_q)
        begin
            high_cnt_q <= high_cnt_q + 8'h01;
        end
        else
        begin
            low_cnt_q <= 8'h00;
        end
    end

    // Control register; the calibrate bit is a self-clearing trigger
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_sel_q  <= ACF_CTRL_DIV_RST;
            soft_cal_q <= 1'b0;
        end
        else
        begin
            soft_cal_q <= ctrl_wr && ctrl_wdata[ACF_CTRL_CAL_BIT];
            if (ctrl_wr)
                div_sel_q <= ctrl_wdata[ACF_CTRL_DIV_BIT];
        end
    end

    // Output data clock, held still during calibration unless output_clock_reset clears it
    assign div_top  = div_sel_q ? ACF_DIV_SLOW : ACF_DIV_FAST;
    assign div_tick = (div_cnt_q == div_top);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_cnt_q <= 2'h0;
            oclk_q    <= 1'b0;
        end
        else if (output_clock_reset)
        begin
            div_cnt_q <= 2'h0;
            oclk_q    <= 1'b0;
        end
        else
        begin
            div_cnt_q <= div_tick ? 2'h0 : div_cnt_q + 2'h1;
            if (div_tick && !cal_active_q)
                oclk_q <= !oclk_q;
        end
    end

    // Clipped sample buses and range flag
    assign clip_now = outside(raw_result.i_val) ||
                      outside(raw_result.q_val);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sample_q <= '0;
            or_pos_q <= 1'b0;
            or_neg_q <= 1'b1;
            fsr_q    <= 1'b1;
        end
        else
        begin
            sample_q.i_code <= clip_code(raw_result.i_val);
            sample_q.q_code <= clip_code(raw_result.q_val);
            or_pos_q        <= clip_now;
            or_neg_q        <= !clip_now;
            fsr_q           <= full_scale_select;
        end
    end

    assign sample_out         = sample_q;
    assign out_of_range_pos   = or_pos_q;
    assign out_of_range_neg   = or_neg_q;
    assign calibration_active = cal_active_q;
    assign full_scale_normal  = fsr_q;
    assign output_data_clock  = oclk_q;

    default clocking acf_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_or_flag_pair: assert property (
        out_of_range_pos != out_of_range_neg)
        else $error("range flag outputs not complementary");
    a_or_follows_data: assert property (
        (outside(raw_result.i_val) || outside(raw_result.q_val))
        |=> out_of_range_pos && (sample_out.i_code == 8'hFF ||
            sample_out.i_code == 8'h00 || sample_out.q_code == 8'hFF ||
            sample_out.q_code == 8'h00))
        else $error("clipped result without range flag");
    a_strap_to_delay: assert property (
        state_q == ACF_ST_STRAP && !calibration_request
        |=> state_q == ACF_ST_DELAY ##1 !calibration_active)
        else $error("power-on delay not entered");
    a_strap_skips_cal: assert property (
        state_q == ACF_ST_STRAP && calibration_request
        |=> state_q == ACF_ST_IDLE && skipped_q && !calibration_active)
        else $error("power-on calibration not skipped");
    a_idle_no_cal: assert property (
        state_q == ACF_ST_IDLE && !pin_trigger && !soft_cal_q
        |=> !calibration_active)
        else $error("calibration without request");
    a_manual_cal_start: assert property (
        state_q == ACF_ST_IDLE && pin_trigger |=> calibration_active)
        else $error("manual request ignored");
    a_pd_holds_delay: assert property (
        state_q == ACF_ST_DELAY && power_down_input |=> $stable(cnt_q))
        else $error("delay counter ran in power-down");
    a_active_matches: assert property (
        calibration_active == (state_q == ACF_ST_CAL))
        else $error("active output disagrees with sequencer");
    a_oclk_quiet_cal: assert property (
        calibration_active ##1 calibration_active
        |-> $stable(output_data_clock))
        else $error("output clock toggled during calibration");
    a_cal_end_resume: assert property (
        state_q == ACF_ST_CAL && cal_done && !output_clock_reset &&
        !div_sel_q |=> !calibration_active ##[1:2] $changed(oclk_q))
        else $error("output clock did not resume after calibration");
    a_fsr_applied: assert property (
        full_scale_select |=> full_scale_normal)
        else $error("full-scale select not applied");

    c_powerup_cal: cover property (
        state_q == ACF_ST_DELAY ##1 state_q == ACF_ST_CAL);
    c_skip_then_manual: cover property (
        skipped_q && state_q == ACF_ST_IDLE ##1 state_q == ACF_ST_CAL);
    c_soft_cal: cover property (soft_cal_q && state_q == ACF_ST_IDLE);
    c_out_of_range: cover property (out_of_range_pos ##1 !out_of_range_pos);

endmodule : acf_ctrl

/* bench/acf_capture_model.sv */
// Capture-side model: drives the request and clock reset pins, takes samples
module acf_capture_model
    import acf_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        strap_high,
    input  wire logic        req_go,
    input  wire logic        glitch,
    input  wire logic        ocr_go,
    input  wire logic        calibration_active,
    input  wire acf_sample_t sample_out,
    output logic             calibration_request,
    output logic             output_clock_reset,
    output logic             busy
);
    timeunit 1ns;
    timeprecision 1ns;

    logic        cal_seen = 1'b0;
    acf_sample_t trusted;

    // Samples are only trusted once a calibration has completed
    always @(posedge hclk)
    begin
        if (calibration_active)
            cal_seen <= 1'b1;
        if (cal_seen && !calibration_active)
            trusted <= sample_out;
        output_clock_reset <= ocr_go && !calibration_active;
    end

    initial
    begin
        calibration_request = 1'b0;
        busy                = 1'b0;
        forever
        begin
            @(posedge hclk);
            if (req_go)
            begin
                busy <= 1'b1;
                calibration_request <= 1'b0;
                repeat (int'(ACF_T_CAL_L_CYC) + 4) @(posedge hclk);
                if (glitch)
                begin
                    // Short high burst then low: restarts the high count
                    calibration_request <= 1'b1;
                    repeat (40) @(posedge hclk);
                    calibration_request <= 1'b0;
                    repeat (6) @(posedge hclk);
                end
                calibration_request <= 1'b1;
                repeat (int'(ACF_T_CAL_H_CYC) + 4) @(posedge hclk);
                busy <= 1'b0;
            end
            else if (!busy)
                calibration_request <= strap_high;
        end
    end
endmodule : acf_capture_model

/* bench/test_adc_calibration_and_range_flag.sv */
// Testbench of the calibration sequencer and range flag block
module test_adc_calibration_and_range_flag;
    import acf_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [ACF_CNT_W-1:0] DLY_LONG = 24'h0000C8;

    logic        hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, scratch;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp;
    logic        calibration_request, calibration_delay_select;
    logic        power_down_input, full_scale_select, output_clock_reset;
    acf_raw_t    raw_result;
    acf_sample_t sample_out;
    logic        out_of_range_pos, out_of_range_neg, calibration_active;
    logic        full_scale_normal, output_data_clock;
    logic        strap_high, req_go, glitch, ocr_go, req_q, act_q, odc_q;
    int          n_mismatch, n_compared, rise_age, odc_flips, n, v;
    int          ti[6] = '{-1, 0, 256, 100, 511, 255};
    int          tq[6] = '{0, 255, 128, -512, 300, 0};

    acf_ctrl #(.DLY_LONG_CYC(DLY_LONG)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .calibration_request(calibration_request),
        .calibration_delay_select(calibration_delay_select),
        .power_down_input(power_down_input),
        .full_scale_select(full_scale_select),
        .output_clock_reset(output_clock_reset), .raw_result(raw_result),
        .sample_out(sample_out), .out_of_range_pos(out_of_range_pos),
        .out_of_range_neg(out_of_range_neg),
        .calibration_active(calibration_active),
        .full_scale_normal(full_scale_normal),
        .output_data_clock(output_data_clock));

    acf_capture_model partner (
        .hclk(hclk), .strap_high(strap_high), .req_go(req_go),
        .glitch(glitch), .ocr_go(ocr_go),
        .calibration_active(calibration_active), .sample_out(sample_out),
        .calibration_request(calibration_request),
        .output_clock_reset(output_clock_reset), .busy());

    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // Age of the last request rise, and clock edges seen inside calibration
    always @(posedge hclk)
    begin
        req_q <= calibration_request;
        act_q <= calibration_active;
        odc_q <= output_data_clock;
        rise_age <= (calibration_request && !req_q) ? 1 : rise_age + 1;
        if (calibration_active && act_q && output_data_clock !== odc_q)
            odc_flips <= odc_flips + 1;
    end

    task automatic test_done;
        if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_rng(input string what, input int lo, input int hi,
                           input int got);
        n_compared++;
        if (got < lo || got > hi)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d",
                     what, lo, hi, got);
        end
    endtask : chk_rng

    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        rd = hrdata;
        chk("bus response", 32'h0, hresp);
    endtask : ahb

    task automatic reg_chk(input string what, input logic [31:0] a,
                           input logic [31:0] exp);
        logic [31:0] d;
        ahb(1'b0, a, 32'h0, d);
        chk(what, exp, d);
    endtask : reg_chk

    task automatic power_up(input logic strap, input logic dsel,
                            input logic pd);
        hresetn <= 1'b0;
        strap_high <= strap;
        calibration_delay_select <= dsel;
        power_down_input <= pd;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : power_up

    // Cycles until calibration_active reaches lvl, or -1 on timeout
    task automatic wait_act(input logic lvl, input int max, output int c);
        c = 0;
        while (calibration_active !== lvl && c <= max)
        begin
            @(negedge hclk);
            c++;
        end
        if (c > max)
            c = -1;
    endtask : wait_act

    function automatic logic [7:0] clip(input int x);
        return x < 0 ? 8'h00 : (x > 255 ? 8'hFF : 8'(x));
    endfunction : clip

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        calibration_delay_select = 1'b1;
        power_down_input = 1'b1;
        full_scale_select = 1'b1;
        raw_result = '0;
        strap_high = 1'b0;
        req_go = 1'b0;
        glitch = 1'b0;
        ocr_go = 1'b0;
        repeat (5) @(negedge hclk);
        chk("reset flags", 32'h1, {out_of_range_pos, out_of_range_neg});
        chk("reset outputs", 32'h2, {calibration_active, full_scale_normal,
                                     output_data_clock});
        @(posedge hclk);
        power_up(1'b0, 1'b1, 1'b1);
        repeat (100) @(posedge hclk);
        chk("held by power-down", 32'h0, calibration_active);
        power_down_input <= 1'b0;
        wait_act(1'b1, 400, n);
        chk_rng("long delay", 196, 206, n);
        wait_act(1'b0, 2000, n);
        chk_rng("power-on cal length", 1398, 1402, n);
        chk("clock frozen", 32'h0, odc_flips);
        reg_chk("status after cal", ACF_OFS_STATUS, 32'h14);
        @(negedge hclk);
        v = output_data_clock;
        repeat (3) @(negedge hclk);
        chk("clock resumes", !v, output_data_clock);
        ahb(1'b1, ACF_OFS_CTRL, 32'h1, scratch);
        reg_chk("ctrl readback", ACF_OFS_CTRL, 32'h1);
        // Slow divider: exactly one toggle in any four cycles
        @(negedge hclk);
        v = output_data_clock;
        repeat (4) @(negedge hclk);
        chk("slow clock", !v, output_data_clock);
        ahb(1'b1, ACF_OFS_CTRL, 32'h0, scratch);
        reg_chk("unmapped read", 32'h0000000C, 32'h0);
        for (int k = 0; k < 6; k++)
        begin
            @(posedge hclk);
            raw_result <= '{i_val: 10'(ti[k]), q_val: 10'(tq[k])};
            repeat (2) @(posedge hclk);
            @(negedge hclk);
            v = (ti[k] < 0 || ti[k] > 255 || tq[k] < 0 || tq[k] > 255);
            chk("clipped sample", {clip(ti[k]), clip(tq[k])}, sample_out);
            chk("range flags", v ? 2'h2 : 2'h1,
                {out_of_range_pos, out_of_range_neg});
        end
        reg_chk("result reg", ACF_OFS_RESULT, 32'h000000FF);
        for (int f = 0; f < 2; f++)
        begin
            @(posedge hclk);
            full_scale_select <= f[0];
            repeat (3) @(posedge hclk);
            chk("range select", f[0], full_scale_normal);
            reg_chk("status range", ACF_OFS_STATUS, f ? 32'h14 : 32'h04);
        end
        ocr_go <= 1'b1;
        repeat (4) @(negedge hclk);
        chk("clock reset", 32'h0, output_data_clock);
        ocr_go <= 1'b0;
        ahb(1'b1, ACF_OFS_CTRL, 32'h2, scratch);
        wait_act(1'b1, 10, n);
        chk_rng("soft trigger start", 0, 4, n);
        reg_chk("trigger self clears", ACF_OFS_CTRL, 32'h0);
        wait_act(1'b0, 2000, n);
        chk_rng("soft cal length", 1395, 1402, n);
        @(posedge hclk);
        power_up(1'b0, 1'b0, 1'b0);
        wait_act(1'b1, 3000, n);
        chk_rng("short delay", 2496, 2506, n);
        wait_act(1'b0, 2000, n);
        @(posedge hclk);
        power_up(1'b1, 1'b0, 1'b0);
        wait_act(1'b1, 3000, n);
        chk_rng("no cal after skip", -1, -1, n);
        reg_chk("status skipped", ACF_OFS_STATUS, 32'h18);
        for (int r = 0; r < 2; r++)
        begin
            @(posedge hclk);
            glitch <= (r == 0);
            req_go <= 1'b1;
            @(posedge hclk);
            req_go <= 1'b0;
            wait_act(1'b1, 400, n);
            chk_rng("request to start", 80, 82, rise_age);
            wait_act(1'b0, 2000, n);
            chk_rng("manual cal length", 1398, 1402, n);
        end
        reg_chk("status manual", ACF_OFS_STATUS, 32'h1C);
        test_done();
    end

    initial
    begin
        repeat (60000) @(posedge hclk);
        n_mismatch++;
        test_done();
    end
endmodule : test_adc_calibration_and_range_flag
